// ### hdl/mpc_pkg.sv
// Package of constants and types for the motor phase commutator
package mpc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the APB word grid
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONFIG    = 8'h00;
  localparam logic [7:0] OFS_CYCLE_LEN = 8'h04;
  localparam logic [7:0] OFS_SINGLE    = 8'h08;
  localparam logic [7:0] OFS_OVERLAP   = 8'h0c;
  localparam logic [7:0] OFS_SHIFT     = 8'h10;
  localparam logic [7:0] OFS_SPEED     = 8'h14;
  localparam logic [7:0] OFS_CEILING   = 8'h18;
  localparam logic [7:0] OFS_POSITION  = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         CFG_FOUR_PHASE_BIT = 1;
  localparam int         CFG_FULL_COUNT_BIT = 2;
  localparam logic [7:0] RST_REG            = 8'h00;

  // ----------------------------------------------------------------
  // Timing: advance window unit and its cycle count
  // ----------------------------------------------------------------
  localparam int WINDOW_UNIT_NS = 8000;
  localparam int CLK_PERIOD_NS  = 5;
  localparam int WINDOW_UNIT_CYC = (WINDOW_UNIT_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   WINDOW_UNIT_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Software settings as one carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] config_bits;
    logic [7:0] cycle_length;
    logic [7:0] single_phase;
    logic [7:0] overlap;
    logic [7:0] index_shift;
    logic [7:0] speed_scale;
    logic [7:0] ceiling;
  } mpc_cfg_t;

endpackage

// ### hdl/mpc_commutator.sv
// Motor phase commutator with APB register slave
`timescale 1ns/1ps
module mpc_commutator
  import mpc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Encoder pins
  input  wire logic        enc_chan_a,
  input  wire logic        enc_chan_b,
  input  wire logic        enc_index,
  // Phase enables
  output logic             phase_out_first,
  output logic             phase_out_second,
  output logic             phase_out_third,
  output logic             phase_out_fourth
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  mpc_cfg_t          cfg;
  logic              access;
  logic              mapped;
  logic [6:0]        position;
  logic [7:0]        advance_mag;
  logic              direction_fwd;

  assign access = psel && penable && pready;

  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      OFS_CONFIG, OFS_CYCLE_LEN, OFS_SINGLE, OFS_OVERLAP,
      OFS_SHIFT, OFS_SPEED, OFS_CEILING, OFS_POSITION: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // One wait state: ready rises the cycle after the access phase starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Length, single, overlap and ceiling keep seven bits; the top bit reads zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '{default: RST_REG};
    end else if (access && pwrite) begin
      unique case (paddr)
        OFS_CONFIG:    cfg.config_bits  <= pwdata[7:0];
        OFS_CYCLE_LEN: cfg.cycle_length <= {1'b0, pwdata[6:0]};
        OFS_SINGLE:    cfg.single_phase <= {1'b0, pwdata[6:0]};
        OFS_OVERLAP:   cfg.overlap      <= {1'b0, pwdata[6:0]};
        OFS_SHIFT:     cfg.index_shift  <= pwdata[7:0];
        OFS_SPEED:     cfg.speed_scale  <= pwdata[7:0];
        OFS_CEILING:   cfg.ceiling      <= {1'b0, pwdata[6:0]};
        default:       cfg              <= cfg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Loaded in the wait state so the data already stand at the ready edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready && !pwrite) begin
      unique case (paddr)
        OFS_CONFIG:    prdata <= {24'h00_0000, cfg.config_bits};
        OFS_CYCLE_LEN: prdata <= {24'h00_0000, cfg.cycle_length};
        OFS_SINGLE:    prdata <= {24'h00_0000, cfg.single_phase};
        OFS_OVERLAP:   prdata <= {24'h00_0000, cfg.overlap};
        OFS_SHIFT:     prdata <= {24'h00_0000, cfg.index_shift};
        OFS_SPEED:     prdata <= {24'h00_0000, cfg.speed_scale};
        OFS_CEILING:   prdata <= {24'h00_0000, cfg.ceiling};
        OFS_POSITION:  prdata <= {15'h0000, direction_fwd, advance_mag, 1'b0, position};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  logic four_phase;
  logic full_count;
  assign four_phase = cfg.config_bits[CFG_FOUR_PHASE_BIT];
  assign full_count = cfg.config_bits[CFG_FULL_COUNT_BIT];

  // ----------------------------------------------------------------
  // Encoder synchronisers and decode
  // ----------------------------------------------------------------
  logic [2:0] sync_meta;
  logic [2:0] sync_now;
  logic [2:0] sync_prev;

  // Only the second and third stages feed decode; the first may still be settling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_meta <= 3'h0;
      sync_now  <= 3'h0;
      sync_prev <= 3'h0;
    end else begin
      sync_meta <= {enc_index, enc_chan_b, enc_chan_a};
      sync_now  <= sync_meta;
      sync_prev <= sync_now;
    end
  end

  logic step;
  logic step_up;
  logic index_rise;

  // Full count mode moves once per quadrature cycle, on the rise of A
  always_comb begin
    index_rise = sync_now[2] && !sync_prev[2];
    if (full_count) begin
      step    = sync_now[0] && !sync_prev[0];
      step_up = !sync_now[1];
    end else begin
      step    = (sync_now[0] ^ sync_prev[0]) ^ (sync_now[1] ^ sync_prev[1]);
      step_up = sync_now[0] ^ sync_prev[1];
    end
  end

  // ----------------------------------------------------------------
  // Circular position counter
  // ----------------------------------------------------------------
  logic [6:0] ring_last;
  assign ring_last = cfg.cycle_length[6:0] - 7'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      position      <= 7'h00;
      direction_fwd <= 1'b1;
    end else begin
      if (step) begin
        direction_fwd <= step_up;
      end
      // A shorter ring written mid-run would strand the count; restart at zero
      if (index_rise || cfg.cycle_length == 8'h00 || position > ring_last) begin
        position <= 7'h00;
      end else if (step && step_up) begin
        position <= (position == ring_last) ? 7'h00 : position + 7'h01;
      end else if (step) begin
        position <= (position == 7'h00) ? ring_last : position - 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Speed-proportional advance
  // ----------------------------------------------------------------
  localparam int UNIT_W = $clog2(WINDOW_UNIT_CYC + 1);
  localparam logic [UNIT_W-1:0] UNIT_LAST = UNIT_W'(WINDOW_UNIT_CYC - 1);

  logic [UNIT_W-1:0] unit_cnt;
  logic [7:0]        slot_cnt;
  logic signed [8:0] steps_acc;
  logic              window_end;

  assign window_end = (unit_cnt == UNIT_LAST) && (slot_cnt == cfg.speed_scale);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_cnt <= '0;
      slot_cnt <= 8'h00;
    end else if (unit_cnt == UNIT_LAST) begin
      unit_cnt <= '0;
      slot_cnt <= (slot_cnt >= cfg.speed_scale) ? 8'h00 : slot_cnt + 8'h01;
    end else begin
      unit_cnt <= unit_cnt + UNIT_W'(1);
    end
  end

  // Steps are counted in the ring's own units, so advance matches them
  // Saturating, so a long fast window cannot wrap to a small advance
  logic signed [8:0] steps_next;
  always_comb begin
    steps_next = steps_acc;
    if (step && step_up && steps_acc != 9'sh0ff) begin
      steps_next = steps_acc + 9'sh001;
    end else if (step && !step_up && steps_acc != -9'sh0ff) begin
      steps_next = steps_acc - 9'sh001;
    end
  end

  logic [7:0] steps_mag;
  assign steps_mag = steps_next[8] ? 8'(-steps_next) : steps_next[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      steps_acc   <= 9'sh000;
      advance_mag <= 8'h00;
    end else if (window_end) begin
      steps_acc   <= 9'sh000;
      advance_mag <= (steps_mag > cfg.ceiling) ? cfg.ceiling : steps_mag;
    end else begin
      steps_acc <= steps_next;
    end
  end

  // ----------------------------------------------------------------
  // Phase decode
  // ----------------------------------------------------------------
  logic signed [10:0] eff_pos;
  logic signed [10:0] ring_s;
  logic signed [10:0] eff_rem;
  logic        [7:0]  seg_len;
  logic        [7:0]  seg_idx;
  logic        [7:0]  seg_ofs;
  logic        [2:0]  n_phase;
  logic        [3:0]  next_phases;

  // Advance leads in the direction of travel
  always_comb begin
    ring_s  = 11'(cfg.cycle_length);
    eff_pos = 11'(position) + 11'(signed'(cfg.index_shift))
            + (direction_fwd ? 11'(advance_mag) : -11'(advance_mag));
    eff_rem = (ring_s == 11'sd0) ? 11'sd0 : eff_pos % ring_s;
    if (eff_rem < 11'sd0) begin
      eff_rem = eff_rem + ring_s;
    end
    seg_len = cfg.single_phase + cfg.overlap;
    n_phase = four_phase ? 3'd4 : 3'd3;
    seg_idx = (seg_len == 8'h00) ? 8'hff : 8'(eff_rem) / seg_len;
    seg_ofs = (seg_len == 8'h00) ? 8'h00 : 8'(eff_rem) % seg_len;
    next_phases = 4'h0;
    // Rising position walks upward through the phases
    if (seg_idx < 8'(n_phase)) begin
      next_phases[seg_idx[1:0]] = 1'b1;
      if (seg_ofs >= cfg.single_phase) begin
        next_phases[(seg_idx[1:0] == 2'(n_phase - 3'd1)) ? 2'd0
                    : seg_idx[1:0] + 2'd1] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Phase output registers
  // ----------------------------------------------------------------
  // Fourth gated again so three-phase mode never drives it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_out_first  <= 1'b0;
      phase_out_second <= 1'b0;
      phase_out_third  <= 1'b0;
      phase_out_fourth <= 1'b0;
    end else begin
      phase_out_first  <= next_phases[0];
      phase_out_second <= next_phases[1];
      phase_out_third  <= next_phases[2];
      phase_out_fourth <= next_phases[3] && four_phase;
    end
  end

endmodule // mpc_commutator

// ### sim/mpc_checker.sv
// Port checker for the motor phase commutator
`timescale 1ns/1ps
module mpc_checker
  import mpc_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic        enc_chan_a,
  input wire logic        enc_chan_b,
  input wire logic        enc_index,
  input wire logic        phase_out_first,
  input wire logic        phase_out_second,
  input wire logic        phase_out_third,
  input wire logic        phase_out_fourth
);
  logic       four;
  logic [2:0] fh;
  wire logic  mapped = paddr[1:0] == 2'b00 && paddr <= OFS_POSITION;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of the phase-count bit; history covers the phase pipeline lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      four <= 1'b0;
      fh   <= 3'b000;
    end else begin
      fh <= {fh[1:0], four};
      if (psel && penable && pready && pwrite && paddr == OFS_CONFIG) begin
        four <= pwdata[CFG_FOUR_PHASE_BIT];
      end
    end
  end
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_done;
    pready ##1 !pready;
  endsequence
  a_ready_one_wait: assert property (s_wait |=> s_done) else $error("pready late or long");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray pready");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr) else $error("no error");
  a_no_err_mapped: assert property (pready && mapped |-> !pslverr) else $error("false error");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read data not zero");
  a_fourth_three: assert property (!four && fh == 3'b000 |-> !phase_out_fourth)
    else $error("fourth phase on in three-phase mode");
  a_two_at_most: assert property ($countones({phase_out_first, phase_out_second,
    phase_out_third, phase_out_fourth}) <= 2) else $error("more than two phases on");
endmodule // mpc_checker

bind mpc_commutator mpc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .enc_chan_a(enc_chan_a), .enc_chan_b(enc_chan_b),
  .enc_index(enc_index), .phase_out_first(phase_out_first),
  .phase_out_second(phase_out_second), .phase_out_third(phase_out_third),
  .phase_out_fourth(phase_out_fourth));

// ### sim/mpc_encoder_model.sv
// Incremental shaft encoder model
`timescale 1ns/1ps
module mpc_encoder_model (
  // Clock
  input wire logic pclk,
  // Encoder pins
  output logic     enc_chan_a,
  output logic     enc_chan_b,
  output logic     enc_index
);
  logic [1:0] q;
  initial begin
    q          = 2'd0;
    enc_chan_a = 1'b0;
    enc_chan_b = 1'b0;
    enc_index  = 1'b0;
  end
  // One channel edge; forward has A leading B
  task automatic step(input logic fwd);
    q = fwd ? q + 2'd1 : q - 2'd1;
    enc_chan_a <= q[1] ^ q[0];
    enc_chan_b <= q[1];
    repeat (3) @(posedge pclk);
  endtask
  task automatic index_pulse;
    enc_index <= 1'b1;
    repeat (4) @(posedge pclk);
    enc_index <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
endmodule // mpc_encoder_model

// ### sim/motor_phase_commutator_bench.sv
// Self-checking bench for the motor phase commutator
`timescale 1ns/1ps
module motor_phase_commutator_bench;
  import mpc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr;
  wire logic   ea, eb, ei;
  wire logic [3:0] ph;
  int          n_fail, check_count;
  mpc_commutator u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enc_chan_a(ea), .enc_chan_b(eb), .enc_index(ei),
    .phase_out_first(ph[0]), .phase_out_second(ph[1]), .phase_out_third(ph[2]),
    .phase_out_fourth(ph[3]));
  mpc_encoder_model u_enc (.pclk(pclk), .enc_chan_a(ea), .enc_chan_b(eb), .enc_index(ei));
  always #2.5 pclk = ~pclk;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk("pready", 32'h1, {31'h0, pready});
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk("read error", 32'h0, {31'h0, e});
    chk("read data", ex, r);
  endtask
  // Expected enables from position, single, overlap and phase count
  function automatic logic [3:0] pexp(int e, int s, int o, int n);
    pexp = 4'h0;
    if (e / (s + o) < n) begin
      pexp[e / (s + o)] = 1'b1;
      if (e % (s + o) >= s) pexp[(e / (s + o) + 1) % n] = 1'b1;
    end
  endfunction
  task automatic phchk(input logic [3:0] ex);
    repeat (8) @(posedge pclk);
    chk("phases", {28'h0, ex}, {28'h0, ph});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 7; i++) rchk(8'(i * 4), 32'h0);
    rchk(OFS_POSITION, 32'h0001_0000);
    wr(OFS_CYCLE_LEN, 32'hff);
    rchk(OFS_CYCLE_LEN, 32'h7f);
    wr(OFS_SPEED, 32'hff);
    rchk(OFS_SPEED, 32'hff);
    wr(OFS_SPEED, 32'h0);
    apb(1'b1, 8'h20, 32'h5, r, e);
    chk("unmapped write", 32'h1, {31'h0, e});
    apb(1'b0, 8'h22, 32'h0, r, e);
    chk("unmapped read", 32'h1, {31'h0, e});
  endtask
  task automatic t_three;
    wr(OFS_CONFIG, 32'h0);
    wr(OFS_CYCLE_LEN, 32'd12);
    wr(OFS_SINGLE, 32'd3);
    wr(OFS_OVERLAP, 32'd1);
    u_enc.index_pulse();
    phchk(pexp(0, 3, 1, 3));
    for (int p = 1; p <= 13; p++) begin
      u_enc.step(1'b1);
      phchk(pexp(p % 12, 3, 1, 3));
    end
    u_enc.step(1'b0);
    u_enc.step(1'b0);
    phchk(pexp(11, 3, 1, 3));
    rchk(OFS_POSITION, 32'd11);
  endtask
  task automatic t_four;
    wr(OFS_CONFIG, 32'h6);
    wr(OFS_CYCLE_LEN, 32'd16);
    wr(OFS_SHIFT, 32'hff);
    u_enc.index_pulse();
    phchk(pexp(15, 3, 1, 4));
    for (int p = 0; p < 6; p++) begin
      repeat (4) u_enc.step(1'b1);
      phchk(pexp(p, 3, 1, 4));
      chk("opposite pair", 32'h0, {31'h0, (ph[0] & ph[2]) | (ph[1] & ph[3])});
    end
    repeat (4) u_enc.step(1'b0);
    phchk(pexp(4, 3, 1, 4));
  endtask
  task automatic t_adv;
    wr(OFS_CONFIG, 32'h2);
    wr(OFS_SHIFT, 32'h0);
    wr(OFS_CEILING, 32'h82);
    rchk(OFS_CEILING, 32'h2);
    u_enc.index_pulse();
    // Longer than two windows of steady motion, so a whole window is latched
    repeat (1099) u_enc.step(1'b1);
    rchk(OFS_POSITION, 32'h0001_020b);
    phchk(pexp(13, 3, 1, 4));
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    check_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_three();
    t_four();
    t_adv();
    wrap_up();
  end
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
endmodule // motor_phase_commutator_bench
